//--- shared/dds_defines.svh
`ifndef DDS_DEFINES_SVH
`define DDS_DEFINES_SVH

// Code width: 16 for the wide variant, 14 for the narrow one
`define DDS_DATA_W 16
`define DDS_ADDR_W 2
// One frame is the address pair followed by the code
`define DDS_FRAME_W (`DDS_DATA_W + `DDS_ADDR_W)
// Top code bit, set alone for the midscale preset
`define DDS_MID_BIT (`DDS_DATA_W - 1)
// Output is -Vref * code / full scale
`define DDS_FULL_SCALE (2 ** `DDS_DATA_W)
// Width of the sampled pin bundle
`define DDS_PIN_W 6
// Synchroniser reset value: the idle pin levels (clock low, deselected,
// load and preset high), so no false edge or frame follows reset
`define DDS_PINS_IDLE 6'h16

// Channel address decode
`define DDS_ADDR_NONE 2'h0
`define DDS_ADDR_A 2'h1
`define DDS_ADDR_B 2'h2
`define DDS_ADDR_BOTH 2'h3

// Power-on value of every code register
`define DDS_CODE_ZERO {`DDS_DATA_W{1'b0}}

`endif

//--- shared/dds_pkg.sv
`include "dds_defines.svh"

package dds_pkg;

    typedef logic [`DDS_DATA_W-1:0] dds_code_t;

    // Pins after the two-stage synchroniser
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic serial_in;
        logic load_outputs_n;
        logic preset_n;
        logic midscale_sel;
    } dds_pins_t;

    // Last frame held in the shift register, first-sent bit on top
    typedef struct packed {
        logic channel_addr_hi;
        logic channel_addr_lo;
        dds_code_t data;
    } dds_frame_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FRAME = 3'b010,
        ST_COMMIT = 3'b100
    } dds_state_t;

endpackage

//--- rtl/dds_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module dds_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // Two flops; the first is read by the second only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

`default_nettype wire

//--- rtl/dds_serial_load.sv
`timescale 1ns/1ns
`default_nettype none
`include "dds_defines.svh"

module dds_serial_load (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic SERIAL_IN,
    input wire logic LOAD_OUTPUTS_N,
    input wire logic PRESET_N,
    input wire logic MIDSCALE_SEL,
    output dds_pkg::dds_code_t INPUT_A_CODE,
    output dds_pkg::dds_code_t INPUT_B_CODE,
    output dds_pkg::dds_code_t DAC_A_CODE,
    output dds_pkg::dds_code_t DAC_B_CODE,
    output logic FRAME_ACTIVE
);
    import dds_pkg::*;

    dds_pins_t pins_raw;
    dds_pins_t pins;
    logic sclk_prev_reg;
    logic [`DDS_FRAME_W-1:0] shift_reg;
    dds_state_t state_reg;
    dds_state_t state_next;
    dds_code_t input_a_reg;
    dds_code_t input_b_reg;
    dds_code_t dac_a_reg;
    dds_code_t dac_b_reg;
    dds_code_t input_a_next;
    dds_code_t input_b_next;
    dds_code_t dac_a_next;
    dds_code_t dac_b_next;
    dds_code_t preset_code;
    dds_frame_t frame;
    logic sclk_rise;
    logic shift_en;
    logic commit;
    logic write_a;
    logic write_b;
    logic presetting;
    logic transparent;

    // Rising edge seen between two samples of a slow pin
    function automatic logic rose(input logic prev, input logic cur);
        return !prev && cur;
    endfunction

    // Preset code: zero, or the top bit alone for midscale
    function automatic dds_code_t preset_value(input logic midscale);
        dds_code_t v;
        v = `DDS_CODE_ZERO;
        v[`DDS_MID_BIT] = midscale;
        return v;
    endfunction

    // All pins come from the host's domain and are sampled twice
    assign pins_raw = '{sclk: SCLK, cs_n: CS_N, serial_in: SERIAL_IN,
                        load_outputs_n: LOAD_OUTPUTS_N, preset_n: PRESET_N,
                        midscale_sel: MIDSCALE_SEL};

    dds_pin_sync #(
        .W(`DDS_PIN_W),
        .RST_VAL(`DDS_PINS_IDLE)
    ) u_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .d(pins_raw),
        .q(pins)
    );

    // Serial clock edge from the synchronised copy only
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= pins.sclk;
        end
    end

    assign sclk_rise = rose(sclk_prev_reg, pins.sclk);

    // Shift only inside a frame; data and clock share the same sync delay
    assign shift_en = (state_reg == ST_FRAME) && !pins.cs_n && sclk_rise;

    // Register keeps exactly one frame, so older bits fall off the top
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            shift_reg <= {`DDS_FRAME_W{1'b0}};
        end else if (shift_en) begin
            shift_reg <= {shift_reg[`DDS_FRAME_W-2:0], pins.serial_in};
        end
    end

    // Frame view: address on top, code below
    assign frame = dds_frame_t'(shift_reg);

    // Frame sequencing; commit is one cycle after chip select rises
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (!pins.cs_n) begin
                    state_next = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (pins.cs_n) begin
                    state_next = ST_COMMIT;
                end
            end
            ST_COMMIT: begin
                state_next = pins.cs_n ? ST_IDLE : ST_FRAME;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Address decode; the shift register is quiet here as it shifts
    // only in ST_FRAME with chip select low
    assign commit = (state_reg == ST_COMMIT);
    assign write_a = commit && ({frame.channel_addr_hi, frame.channel_addr_lo} == `DDS_ADDR_A
        || {frame.channel_addr_hi, frame.channel_addr_lo} == `DDS_ADDR_BOTH);
    assign write_b = commit && ({frame.channel_addr_hi, frame.channel_addr_lo} == `DDS_ADDR_B
        || {frame.channel_addr_hi, frame.channel_addr_lo} == `DDS_ADDR_BOTH);

    // Preset wins over everything; it is a level, not an edge
    assign presetting = !pins.preset_n;
    assign preset_code = preset_value(pins.midscale_sel);
    assign transparent = !pins.load_outputs_n;

    // Input registers
    assign input_a_next = presetting ? preset_code
                        : write_a ? frame.data : input_a_reg;
    assign input_b_next = presetting ? preset_code
                        : write_b ? frame.data : input_b_reg;

    // Output registers follow the new input value in the same cycle,
    // so a commit with load held low reaches the output at once
    assign dac_a_next = presetting ? preset_code
                      : transparent ? input_a_next : dac_a_reg;
    assign dac_b_next = presetting ? preset_code
                      : transparent ? input_b_next : dac_b_reg;

    // Power-on clears all four code registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            input_a_reg <= `DDS_CODE_ZERO;
            input_b_reg <= `DDS_CODE_ZERO;
            dac_a_reg <= `DDS_CODE_ZERO;
            dac_b_reg <= `DDS_CODE_ZERO;
        end else begin
            input_a_reg <= input_a_next;
            input_b_reg <= input_b_next;
            dac_a_reg <= dac_a_next;
            dac_b_reg <= dac_b_next;
        end
    end

    // Codes for the ladder; it scales each by -Vref / full scale
    assign INPUT_A_CODE = input_a_reg;
    assign INPUT_B_CODE = input_b_reg;
    assign DAC_A_CODE = dac_a_reg;
    assign DAC_B_CODE = dac_b_reg;
    assign FRAME_ACTIVE = state_reg[1];

    // Checks

    sequence s_frame_end;
        (state_reg == ST_FRAME) && pins.cs_n;
    endsequence

    sequence s_commit_plain(logic [1:0] a);
        (state_reg == ST_COMMIT) && pins.preset_n
            && ({frame.channel_addr_hi, frame.channel_addr_lo} == a);
    endsequence

    property p_shift_in;
        @(posedge CLK) disable iff (!RST_B)
        shift_en |=> shift_reg == {$past(shift_reg[`DDS_FRAME_W-2:0]), $past(pins.serial_in)};
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift in wrong");

    property p_idle_hold;
        @(posedge CLK) disable iff (!RST_B)
        (pins.cs_n && state_reg != ST_FRAME) |=> $stable(shift_reg);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("shift moved idle");

    property p_frame_end;
        @(posedge CLK) disable iff (!RST_B)
        s_frame_end |=> (state_reg == ST_COMMIT) ##1 (state_reg != ST_COMMIT);
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("no single commit");

    property p_write_a;
        @(posedge CLK) disable iff (!RST_B)
        s_commit_plain(`DDS_ADDR_A) |=> (input_a_reg == $past(frame.data))
            && $stable(input_b_reg);
    endproperty
    a_write_a: assert property (p_write_a) else $error("channel A write");

    property p_write_none;
        @(posedge CLK) disable iff (!RST_B)
        s_commit_plain(`DDS_ADDR_NONE) |=> $stable(input_a_reg) && $stable(input_b_reg);
    endproperty
    a_write_none: assert property (p_write_none) else $error("none address wrote");

    property p_write_both;
        @(posedge CLK) disable iff (!RST_B)
        s_commit_plain(`DDS_ADDR_BOTH) |=> (input_a_reg == $past(frame.data))
            && (input_b_reg == $past(frame.data));
    endproperty
    a_write_both: assert property (p_write_both) else $error("both write");

    property p_latched;
        @(posedge CLK) disable iff (!RST_B)
        (pins.load_outputs_n && pins.preset_n) |=> $stable(dac_a_reg) && $stable(dac_b_reg);
    endproperty
    a_latched: assert property (p_latched) else $error("output moved latched");

    property p_transparent;
        @(posedge CLK) disable iff (!RST_B)
        (!pins.load_outputs_n && pins.preset_n) |=> (dac_a_reg == input_a_reg)
            && (dac_b_reg == input_b_reg);
    endproperty
    a_transparent: assert property (p_transparent) else $error("not transparent");

    property p_preset;
        @(posedge CLK) disable iff (!RST_B)
        !pins.preset_n |=> (dac_a_reg == $past(preset_code)) && (input_b_reg == $past(preset_code))
            && (input_a_reg == $past(preset_code)) && (dac_b_reg == $past(preset_code));
    endproperty
    a_preset: assert property (p_preset) else $error("preset value");

endmodule

`default_nettype wire

//--- tb/dds_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Host side of the three-wire link, driving on the falling system edge
module dds_host_model (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic serial_in
);
    // Half of the 48 ns serial period, in 4 ns system cycles
    localparam int HALF = 6;

    // Idle link: deselected, serial clock parked low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Low nbits of word go out top bit first; data moves only while clock is low
    task automatic send_frame(input logic [23:0] word, input int nbits);
        idle(1);
        cs_n = 1'b0;
        idle(HALF);
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_in = word[i];
            idle(HALF);
            sclk = 1'b1;
            idle(HALF);
            sclk = 1'b0;
        end
        idle(HALF);
        cs_n = 1'b1;
        // Data line no longer driven with meaning once deselected
        serial_in = ~serial_in;
        idle(3 * HALF);
    endtask

    // Clock pulses while deselected, with the data line moving
    task automatic stray_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            serial_in = ~serial_in;
            idle(HALF);
            sclk = 1'b1;
            idle(HALF);
            sclk = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

//--- tb/dds_serial_load_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "dds_defines.svh"

module dds_serial_load_bench;
    import dds_pkg::*;

    typedef struct packed {
        logic [1:0] addr;
        dds_code_t data;
        logic load_n;
        dds_code_t ia;
        dds_code_t ib;
        dds_code_t da;
        dds_code_t db;
    } dds_row_t;

    localparam dds_code_t MID = {1'b1, {(`DDS_DATA_W - 1){1'b0}}};

    logic clk;
    logic rst_b;
    logic load_n;
    logic preset_n;
    logic mid_sel;
    logic sclk;
    logic cs_n;
    logic serial_in;
    logic frame_active;
    dds_code_t ia;
    dds_code_t ib;
    dds_code_t da;
    dds_code_t db;
    int err_total = 0;
    int total_checks = 0;

    // Each row carries on from the state the previous row left
    dds_row_t rows [5] = '{
        '{2'h1, 16'h1234, 1'b1, 16'h1234, 16'h0000, 16'h0000, 16'h0000},
        '{2'h2, 16'habcd, 1'b1, 16'h1234, 16'habcd, 16'h0000, 16'h0000},
        '{2'h0, 16'hffff, 1'b1, 16'h1234, 16'habcd, 16'h0000, 16'h0000},
        '{2'h3, 16'h5a5a, 1'b0, 16'h5a5a, 16'h5a5a, 16'h5a5a, 16'h5a5a},
        '{2'h1, 16'h0001, 1'b0, 16'h0001, 16'h5a5a, 16'h0001, 16'h5a5a}
    };

    dds_serial_load uut (
        .CLK(clk),
        .RST_B(rst_b),
        .SCLK(sclk),
        .CS_N(cs_n),
        .SERIAL_IN(serial_in),
        .LOAD_OUTPUTS_N(load_n),
        .PRESET_N(preset_n),
        .MIDSCALE_SEL(mid_sel),
        .INPUT_A_CODE(ia),
        .INPUT_B_CODE(ib),
        .DAC_A_CODE(da),
        .DAC_B_CODE(db),
        .FRAME_ACTIVE(frame_active)
    );

    dds_host_model host (
        .clk(clk),
        .sclk(sclk),
        .cs_n(cs_n),
        .serial_in(serial_in)
    );

    // 250 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input dds_code_t exp, input dds_code_t got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk4(input dds_code_t ea, input dds_code_t eb, input dds_code_t xa,
                        input dds_code_t xb);
        chk("input A", ea, ia);
        chk("input B", eb, ib);
        chk("output A", xa, da);
        chk("output B", xb, db);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence; the long waits cover the two-stage pin sampling
    initial begin
        rst_b = 1'b0;
        load_n = 1'b1;
        preset_n = 1'b1;
        mid_sel = 1'b0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk4(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        chk("frame active", 16'h0000, {15'h0000, frame_active});
        foreach (rows[i]) begin
            load_n = rows[i].load_n;
            repeat (4) @(negedge clk);
            host.send_frame({6'h00, rows[i].addr, rows[i].data}, `DDS_FRAME_W);
            chk4(rows[i].ia, rows[i].ib, rows[i].da, rows[i].db);
        end
        load_n = 1'b1;
        repeat (4) @(negedge clk);
        // Leading padding bits would turn the address to both if kept
        host.send_frame({6'h3f, 2'h1, 16'hc3a5}, 24);
        chk4(16'hc3a5, 16'h5a5a, 16'h0001, 16'h5a5a);
        // Frame status must be up while chip select is held low
        fork
            host.send_frame({6'h00, 2'h1, 16'h1111}, `DDS_FRAME_W);
            begin
                repeat (20) @(negedge clk);
                chk("frame active", 16'h0001, {15'h0000, frame_active});
            end
        join
        host.send_frame({6'h00, 2'h2, 16'h2222}, `DDS_FRAME_W);
        chk4(16'h1111, 16'h2222, 16'h0001, 16'h5a5a);
        load_n = 1'b0;
        repeat (6) @(negedge clk);
        load_n = 1'b1;
        repeat (6) @(negedge clk);
        chk4(16'h1111, 16'h2222, 16'h1111, 16'h2222);
        // A shifted register would decode as channel B with new data
        host.send_frame({6'h00, 2'h1, 16'h1111}, `DDS_FRAME_W);
        host.stray_clocks(5);
        host.send_frame(24'h000000, 0);
        chk4(16'h1111, 16'h2222, 16'h1111, 16'h2222);
        // Mid-run reset clears all four codes again and starts no frame
        rst_b = 1'b0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk4(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        chk("frame active", 16'h0000, {15'h0000, frame_active});
        preset_n = 1'b0;
        mid_sel = 1'b1;
        repeat (6) @(negedge clk);
        chk4(MID, MID, MID, MID);
        mid_sel = 1'b0;
        repeat (6) @(negedge clk);
        chk4(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        preset_n = 1'b1;
        repeat (4) @(negedge clk);
        end_of_test();
    end

    // Whole run needs about 2500 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        end_of_test();
    end
endmodule

`default_nettype wire
